// >>> logic/diag_byte_store.sv
// 128-byte store for channel entries and interrupt detail, registered read
// assumes the reader holds raddr one cycle before using rdata
`timescale 1ns/1ps
module diag_byte_store (
  store_if.store bus
);
  logic [7:0] mem [0:127];

  always_ff @(posedge bus.clk) begin
    if (bus.we) begin
      mem[bus.waddr] <= bus.wdata;
    end
  end

  always_ff @(posedge bus.clk) begin
    bus.rdata <= mem[bus.raddr];
  end
endmodule : diag_byte_store

// >>> logic/diag_interrupt_frame_builder.sv
// slave diagnostic frame builder: station header, redundancy block, channel entries,
// interrupt section; also codes module faults and screens parameter writes
// assumes frame reader, parameter source and store writer run on MCLK; fault pins async
//
// How it works
// - supply voltage missing reports code 17
// - HART no reply or timing: code 19
// - reference junction fault reports code 21
// - safe shutdown switched on: code 24
// - HART PV code 29, auxiliary 30
// - faulty parameter rejected, old set kept
// - rejection raises no parameter error diagnostic
// - faulty parameters raise no update interrupt
// - redundancy block only in redundant operation
// - redundancy block follows manufacturer identifier
// - interrupt section at most 48 bytes
// - interrupt section follows channel diagnostics
// - pending interrupt truncates channel entries
// - diagnostic: 4-byte header plus 44 bytes
// - hardware: 4-byte header plus 4 bytes
// - remove/insert: header plus 5 bytes
// - update: header plus 2 bytes
// - diagnostic bytes x+4..x+7 hold record 0
// - diagnostic bytes x+8..x+43 hold record 1
// - update bytes: record index, unreported count
`timescale 1ns/1ps
`include "diag_frame_consts.svh"
module diag_interrupt_frame_builder (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic SUPPLY_LOW,
  input wire logic HART_NO_REPLY,
  input wire logic REF_JUNC_FAULT,
  input wire logic SHUTDOWN_ON,
  input wire logic HART_PV_LIMIT,
  input wire logic HART_AUX_LIMIT,
  output logic [4:0] ERR_CODE,
  output logic ERR_ACTIVE,
  input wire logic PARAM_STROBE,
  input wire logic [7:0] PARAM_INDEX,
  input wire logic [7:0] PARAM_VALUE,
  input wire logic PARAM_FAULTY,
  output logic [7:0] PARAM_ACTIVE,
  input wire logic REDUNDANT_MODE,
  input wire logic [47:0] STATION_HDR,
  input wire logic [31:0] REDUN_STATUS,
  input wire logic [3:0] CHAN_COUNT,
  input wire logic STORE_WE,
  input wire logic [6:0] STORE_ADDR,
  input wire logic [7:0] STORE_DATA,
  input wire logic IRQ_STROBE,
  input wire logic [1:0] IRQ_KIND,
  input wire logic [31:0] IRQ_HDR,
  output logic IRQ_BUSY,
  input wire logic FRAME_REQ,
  output logic FRAME_BUSY,
  output logic FRAME_VALID,
  output logic [7:0] FRAME_DATA,
  output logic FRAME_LAST,
  input wire logic FRAME_READY
);
  function automatic logic [5:0] add_len(input diag_frame_pkg::irq_kind_t k);
    case (k)
      diag_frame_pkg::IRQ_DIAG: add_len = `ADD_DIAG;
      diag_frame_pkg::IRQ_HW: add_len = `ADD_HW;
      diag_frame_pkg::IRQ_PLUG: add_len = `ADD_PLUG;
      default: add_len = `ADD_UPD;
    endcase
  endfunction : add_len

  // byte i of a big-endian word, msb byte first
  function automatic logic [7:0] byte_at(input logic [47:0] w, input logic [5:0] i);
    logic [47:0] s;
    s = w << {i, 3'b000};
    return s[47:40];
  endfunction : byte_at

  // whole channel entries that fit in the room left
  function automatic logic [3:0] chan_fit(input logic [3:0] cnt, input logic [7:0] room);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 1; i < 16; i++) begin
      if (4'(i) <= cnt && 8'(i) * `CHAN_ENTRY_LEN <= room) begin
        n = 4'(i);
      end
    end
    return n;
  endfunction : chan_fit

  diag_frame_pkg::frame_state_t state;
  diag_frame_pkg::irq_kind_t kind;
  diag_frame_pkg::irq_kind_t kind_now;
  logic [5:0] idx;
  logic [7:0] pos;
  logic [7:0] total_len;
  logic [6:0] chan_ptr;
  logic [3:0] entry;
  logic [3:0] ch_n;
  logic primed;
  logic redun_on;
  logic irq_on;
  logic src_ext;
  logic [31:0] sel_hdr;
  logic [7:0] upd_b0;
  logic [7:0] upd_b1;
  logic ext_pend;
  diag_frame_pkg::irq_kind_t ext_kind;
  logic [31:0] ext_hdr;
  logic upd_pend;
  logic [7:0] upd_index;
  logic [7:0] upd_lost;
  logic mem_src;
  logic [7:0] next_byte;
  logic emit_now;
  logic last_now;
  logic irq_done;
  logic irq_now;
  logic [7:0] irq_len_now;
  logic [7:0] pre_now;
  logic [3:0] fit_now;
  logic [7:0] total_now;
  logic upd_event;
  diag_frame_pkg::frame_state_t after_pre;

  store_if sif (.clk(MCLK));

  diag_byte_store store_u (
    .bus(sif)
  );

  fault_type_coder coder_u (
    .clk(MCLK),
    .rst(RESET),
    .fault_raw({HART_AUX_LIMIT, HART_PV_LIMIT, HART_NO_REPLY, REF_JUNC_FAULT,
      SHUTDOWN_ON, SUPPLY_LOW}),
    .code(ERR_CODE),
    .active(ERR_ACTIVE)
  );

  assign sif.we = STORE_WE;
  assign sif.waddr = STORE_ADDR;
  assign sif.wdata = STORE_DATA;
  assign sif.raddr = (state == diag_frame_pkg::S_CHAN) ? `CHAN_BASE + chan_ptr
    : `IRQ_INFO_BASE + {1'b0, idx};

  // layout of the frame about to start, sized with the interrupt in it
  always_comb begin
    irq_now = ext_pend | upd_pend;
    kind_now = ext_pend ? ext_kind : diag_frame_pkg::IRQ_UPD;
    irq_len_now = irq_now ? {2'b00, `IRQ_HDR_LEN + add_len(kind_now)} : 8'h00;
    pre_now = `STN_HDR_LEN + (REDUNDANT_MODE ? `REDUN_LEN : 8'h00);
    fit_now = chan_fit(CHAN_COUNT, `FRAME_MAX - pre_now - irq_len_now);
    total_now = pre_now + {4'h0, fit_now} * `CHAN_ENTRY_LEN + irq_len_now;
  end

  always_comb begin
    mem_src = 1'b0;
    next_byte = 8'h00;
    case (state)
      diag_frame_pkg::S_HDR: next_byte = byte_at(STATION_HDR, idx);
      diag_frame_pkg::S_REDUN: next_byte = byte_at({REDUN_STATUS, 16'h0000}, idx);
      diag_frame_pkg::S_CHAN: mem_src = 1'b1;
      diag_frame_pkg::S_IHDR: next_byte = byte_at({sel_hdr, 16'h0000}, idx);
      diag_frame_pkg::S_IADD: begin
        if (kind == diag_frame_pkg::IRQ_UPD) begin
          next_byte = (idx == 6'h00) ? upd_b0 : upd_b1;
        end else begin
          mem_src = 1'b1;
        end
      end
      default: next_byte = 8'h00;
    endcase
  end

  // memory bytes wait one cycle so the registered read catches up
  assign emit_now = (state != diag_frame_pkg::S_IDLE) && (!FRAME_VALID || FRAME_READY)
    && (!mem_src || primed);
  assign last_now = pos == total_len - 8'h01;
  assign irq_done = emit_now && last_now && irq_on;
  assign after_pre = (ch_n != 4'h0) ? diag_frame_pkg::S_CHAN : diag_frame_pkg::S_IHDR;
  assign FRAME_BUSY = state != diag_frame_pkg::S_IDLE;
  assign IRQ_BUSY = ext_pend;

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      state <= diag_frame_pkg::S_IDLE;
      idx <= 6'h00;
      pos <= 8'h00;
      chan_ptr <= 7'h00;
      entry <= 4'h0;
      primed <= 1'b0;
    end else if (state == diag_frame_pkg::S_IDLE) begin
      primed <= 1'b0;
      if (FRAME_REQ) begin
        state <= diag_frame_pkg::S_HDR;
        idx <= 6'h00;
        pos <= 8'h00;
        chan_ptr <= 7'h00;
        entry <= 4'h0;
      end
    end else begin
      primed <= mem_src && !emit_now;
      if (emit_now) begin
        pos <= pos + 8'h01;
        idx <= idx + 6'h01;
        if (last_now) begin
          state <= diag_frame_pkg::S_IDLE;
        end else begin
          case (state)
            diag_frame_pkg::S_HDR: begin
              if ({2'b00, idx} == `STN_HDR_LEN - 8'h01) begin
                idx <= 6'h00;
                // directly behind the manufacturer identifier bytes
                state <= redun_on ? diag_frame_pkg::S_REDUN : after_pre;
              end
            end
            diag_frame_pkg::S_REDUN: begin
              if ({2'b00, idx} == `REDUN_LEN - 8'h01) begin
                idx <= 6'h00;
                state <= after_pre;
              end
            end
            diag_frame_pkg::S_CHAN: begin
              chan_ptr <= chan_ptr + 7'h01;
              if ({2'b00, idx} == `CHAN_ENTRY_LEN - 8'h01) begin
                idx <= 6'h00;
                entry <= entry + 4'h1;
                if (entry == ch_n - 4'h1) begin
                  state <= diag_frame_pkg::S_IHDR;
                end
              end
            end
            diag_frame_pkg::S_IHDR: begin
              if (idx == `IRQ_HDR_LEN - 6'h01) begin
                idx <= 6'h00;
                state <= diag_frame_pkg::S_IADD;
              end
            end
            default: state <= state;
          endcase
        end
      end
    end
  end

  // frame contents frozen at start so a late event waits for the next frame, but a late update in an update frame is cleared at its last byte
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      redun_on <= 1'b0;
      irq_on <= 1'b0;
      src_ext <= 1'b0;
      kind <= diag_frame_pkg::IRQ_DIAG;
      sel_hdr <= 32'h00000000;
      upd_b0 <= 8'h00;
      upd_b1 <= 8'h00;
      ch_n <= 4'h0;
      total_len <= `STN_HDR_LEN;
    end else if (state == diag_frame_pkg::S_IDLE && FRAME_REQ) begin
      redun_on <= REDUNDANT_MODE;
      irq_on <= irq_now;
      src_ext <= ext_pend;
      kind <= kind_now;
      sel_hdr <= ext_pend ? ext_hdr : {2'b00, `IRQ_HDR_LEN + `ADD_UPD, `UPD_TYPE_BYTE,
        `UPD_SLOT_BYTE, 8'h00};
      upd_b0 <= upd_index;
      upd_b1 <= upd_lost;
      ch_n <= fit_now;
      total_len <= total_now;
    end
  end

  // one external interrupt held at a time; a strobe on the clearing cycle survives
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      ext_pend <= 1'b0;
      ext_kind <= diag_frame_pkg::IRQ_DIAG;
      ext_hdr <= 32'h00000000;
    end else if (IRQ_STROBE && (!ext_pend || (irq_done && src_ext))) begin
      ext_pend <= 1'b1;
      ext_kind <= diag_frame_pkg::irq_kind_t'(IRQ_KIND);
      ext_hdr <= IRQ_HDR;
    end else if (irq_done && src_ext) begin
      ext_pend <= 1'b0;
    end
  end

  assign upd_event = PARAM_STROBE && !PARAM_FAULTY && PARAM_VALUE != PARAM_ACTIVE;

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      PARAM_ACTIVE <= `PARAM_RESET;
    end else if (PARAM_STROBE && !PARAM_FAULTY) begin
      PARAM_ACTIVE <= PARAM_VALUE;
    end
    // a faulty write falls through silently, no error code or frame entry
  end

  // updates arriving while one is unreported replace its index and are counted
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      upd_pend <= 1'b0;
      upd_index <= 8'h00;
      upd_lost <= 8'h00;
    end else if (upd_event) begin
      upd_pend <= 1'b1;
      upd_index <= PARAM_INDEX;
      if (irq_done && !src_ext) begin
        upd_lost <= 8'h00;
      end else if (upd_pend && upd_lost != `LOST_MAX) begin
        upd_lost <= upd_lost + 8'h01;
      end
    end else if (irq_done && !src_ext) begin
      upd_pend <= 1'b0;
      upd_lost <= 8'h00;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      FRAME_VALID <= 1'b0;
      FRAME_DATA <= 8'h00;
      FRAME_LAST <= 1'b0;
    end else if (emit_now) begin
      FRAME_VALID <= 1'b1;
      FRAME_DATA <= mem_src ? sif.rdata : next_byte;
      FRAME_LAST <= last_now;
    end else if (FRAME_READY) begin
      FRAME_VALID <= 1'b0;
      FRAME_LAST <= 1'b0;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  param_reject_a: assert property (PARAM_STROBE && PARAM_FAULTY |=> $stable(PARAM_ACTIVE))
    else $error("faulty parameter was taken");
  // a finishing update frame may clear the count in the same cycle
  no_param_diag_a: assert property (PARAM_STROBE && PARAM_FAULTY && !irq_done
      |=> $stable(upd_index) && $stable(upd_lost))
    else $error("faulty parameter left a trace");
  no_upd_irq_a: assert property (PARAM_STROBE && PARAM_FAULTY && !upd_pend |=> !upd_pend)
    else $error("update interrupt from faulty parameter");
  redun_gate_a: assert property (state == diag_frame_pkg::S_REDUN |-> redun_on)
    else $error("redundancy block outside redundant mode");
  redun_place_a: assert property (state == diag_frame_pkg::S_REDUN
      && $past(state) != diag_frame_pkg::S_REDUN |-> pos == `STN_HDR_LEN)
    else $error("redundancy block misplaced");
  irq_size_a: assert property (state == diag_frame_pkg::S_IADD
      |-> idx < add_len(kind) && `IRQ_HDR_LEN + add_len(kind) <= `IRQ_SECT_MAX)
    else $error("interrupt section too long");
  irq_place_a: assert property (state == diag_frame_pkg::S_IHDR && idx == 6'h00
      |-> pos == total_len - {2'b00, `IRQ_HDR_LEN} - {2'b00, add_len(kind)})
    else $error("interrupt section misplaced");
  frame_fit_a: assert property (state == diag_frame_pkg::S_IDLE && FRAME_REQ
      |=> total_len <= `FRAME_MAX && ch_n <= $past(CHAN_COUNT))
    else $error("frame overruns its limit");
  diag_len_a: assert property (irq_done && kind == diag_frame_pkg::IRQ_DIAG
      |-> idx == 6'h2b && state == diag_frame_pkg::S_IADD)
    else $error("diagnostic interrupt length wrong");
  hw_plug_len_a: assert property (irq_done && kind inside {diag_frame_pkg::IRQ_HW,
      diag_frame_pkg::IRQ_PLUG} |-> idx == (kind == diag_frame_pkg::IRQ_HW ? 6'h03 : 6'h04))
    else $error("hardware or plug interrupt length wrong");
  upd_len_a: assert property (irq_done && kind == diag_frame_pkg::IRQ_UPD |-> idx == 6'h01)
    else $error("update interrupt length wrong");
  record_map_a: assert property (state == diag_frame_pkg::S_IADD && mem_src
      |-> sif.raddr == `IRQ_INFO_BASE + {1'b0, idx})
    else $error("diagnostic record byte misaddressed");
  upd_bytes_a: assert property (emit_now && state == diag_frame_pkg::S_IADD
      && kind == diag_frame_pkg::IRQ_UPD |=> FRAME_DATA == (idx == 6'h01 ? upd_b0 : upd_b1))
    else $error("update interrupt byte wrong");

  redun_frame_c: cover property (state == diag_frame_pkg::S_REDUN);
  diag_irq_c: cover property (irq_done && kind == diag_frame_pkg::IRQ_DIAG);
  truncated_c: cover property (irq_on && state == diag_frame_pkg::S_IHDR && ch_n < CHAN_COUNT);
  upd_irq_c: cover property (irq_done && kind == diag_frame_pkg::IRQ_UPD);
endmodule : diag_interrupt_frame_builder

// >>> logic/fault_type_coder.sv
// turns module fault pins into one five-bit error type code
// assumes fault pins are asynchronous levels; bit order supply, shutdown, ref, hart, pv, aux
`timescale 1ns/1ps
`include "diag_frame_consts.svh"
module fault_type_coder (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] fault_raw,
  output logic [4:0] code,
  output logic active
);
  logic [5:0] meta;
  logic [5:0] f;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= 6'h00;
      f <= 6'h00;
    end else begin
      meta <= fault_raw;
      f <= meta;
    end
  end

  // supply loss first: it hides every fault behind it
  always_ff @(posedge clk) begin
    if (rst) begin
      code <= `ERR_NONE;
      active <= 1'b0;
    end else begin
      active <= |f;
      casez (f)
        6'b?????1: code <= `ERR_SUPPLY;
        6'b????10: code <= `ERR_SHUTDOWN;
        6'b???100: code <= `ERR_REF_JUNC;
        6'b??1000: code <= `ERR_HART_COMM;
        6'b?10000: code <= `ERR_HART_PV;
        6'b100000: code <= `ERR_HART_AUX;
        default: code <= `ERR_NONE;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  supply_code_a: assert property (f[0] |=> code == `ERR_SUPPLY && active)
    else $error("supply fault not coded 17");
  hart_comm_a: assert property (f == 6'h08 |=> code == `ERR_HART_COMM)
    else $error("hart comm fault not coded 19");
  ref_junc_a: assert property (f == 6'h04 |=> code == `ERR_REF_JUNC)
    else $error("reference fault not coded 21");
  shutdown_code_a: assert property (f[1:0] == 2'b10 |=> code == `ERR_SHUTDOWN)
    else $error("shutdown not coded 24");
  // the coded value belongs to the cycle before, so the pv bit is taken from there
  hart_limits_a: assert property (f[5:4] != 2'b00 && f[3:0] == 4'h0 |=>
      code == ($past(f[4]) ? `ERR_HART_PV : `ERR_HART_AUX))
    else $error("hart limit code wrong");
endmodule : fault_type_coder

// >>> shared/diag_frame_consts.svh
// constants for the diagnostic frame builder: error codes, section lengths, frame layout
// assumes inclusion by bare name from design files
`ifndef DIAG_FRAME_CONSTS_SVH
`define DIAG_FRAME_CONSTS_SVH
`define ERR_SUPPLY 5'h11
`define ERR_HART_COMM 5'h13
`define ERR_REF_JUNC 5'h15
`define ERR_SHUTDOWN 5'h18
`define ERR_HART_PV 5'h1d
`define ERR_HART_AUX 5'h1e
`define ERR_NONE 5'h00
`define IRQ_SECT_MAX 6'h30
`define IRQ_HDR_LEN 6'h04
`define ADD_DIAG 6'h2c
`define ADD_HW 6'h04
`define ADD_PLUG 6'h05
`define ADD_UPD 6'h02
`define STN_HDR_LEN 8'h06
`define REDUN_LEN 8'h04
`define CHAN_ENTRY_LEN 8'h03
`define FRAME_MAX 8'h40
`define CHAN_BASE 7'h00
`define IRQ_INFO_BASE 7'h40
`define PARAM_RESET 8'h00
`define LOST_MAX 8'hff
`define UPD_TYPE_BYTE 8'h06
`define UPD_SLOT_BYTE 8'h00
`endif

// >>> shared/diag_frame_pkg.sv
// types shared by the diagnostic frame builder files
// assumes nothing of its surroundings
package diag_frame_pkg;
  typedef enum logic [1:0] {
    IRQ_DIAG = 2'b00,
    IRQ_HW = 2'b01,
    IRQ_PLUG = 2'b10,
    IRQ_UPD = 2'b11
  } irq_kind_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_HDR = 3'b001,
    S_REDUN = 3'b010,
    S_CHAN = 3'b011,
    S_IHDR = 3'b100,
    S_IADD = 3'b101
  } frame_state_t;
endpackage : diag_frame_pkg

// >>> shared/store_if.sv
// byte store carrier between the frame builder and its memory
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface store_if (
  input wire logic clk
);
  logic we;
  logic [6:0] waddr;
  logic [7:0] wdata;
  logic [6:0] raddr;
  logic [7:0] rdata;
  modport client (output we, output waddr, output wdata, output raddr, input rdata);
  modport store (input clk, input we, input waddr, input wdata, input raddr, output rdata);
endinterface : store_if

// >>> testbench/frame_reader.sv
// frame reader model: asks for one slave diagnostic frame and collects its bytes
// assumes the builder's frame stream on the same clock; it acts on the falling edge
`timescale 1ns/1ps
module frame_reader (
  input wire logic clk,
  input wire logic FRAME_BUSY,
  input wire logic FRAME_VALID,
  input wire logic [7:0] FRAME_DATA,
  input wire logic FRAME_LAST,
  output logic FRAME_REQ,
  output logic FRAME_READY
);
  logic [7:0] got [0:127];
  int count = 0;
  bit seen_last = 1'b0;
  bit slow = 1'b0;
  initial begin
    FRAME_REQ = 1'b0;
    FRAME_READY = 1'b0;
  end
  // random stalls prove that each byte is held until taken
  always @(negedge clk) begin
    FRAME_READY <= slow ? ($urandom_range(2) != 0) : 1'b1;
  end
  always @(posedge clk) begin
    if (FRAME_VALID === 1'b1 && FRAME_READY) begin
      got[count] <= FRAME_DATA;
      count <= count + 1;
      if (FRAME_LAST === 1'b1) seen_last <= 1'b1;
    end
  end
  task automatic read_frame(input bit stall, output bit ok);
    int guard;
    guard = 0;
    @(negedge clk);
    while (FRAME_BUSY !== 1'b0 && guard < 200) begin
      @(negedge clk);
      guard++;
    end
    slow = stall;
    count = 0;
    seen_last = 1'b0;
    // request held over exactly the edge that takes it: busy is low there
    FRAME_REQ = 1'b1;
    @(negedge clk);
    FRAME_REQ = 1'b0;
    guard = 0;
    while (!seen_last && guard < 2000) begin
      @(negedge clk);
      guard++;
    end
    ok = seen_last;
  endtask : read_frame
endmodule : frame_reader

// >>> testbench/tb_top.sv
// self-checking bench for the diagnostic frame builder, with a frame reader model
// assumes the builder, its store, coder and frame_reader are compiled before it
`timescale 1ns/1ps
`include "diag_frame_consts.svh"
module tb_top;
  logic MCLK = 1'b0;
  logic RESET = 1'b1;
  logic [5:0] flt = 6'h00;
  logic [4:0] ERR_CODE;
  logic ERR_ACTIVE, IRQ_BUSY, FRAME_REQ, FRAME_BUSY, FRAME_VALID, FRAME_LAST, FRAME_READY;
  logic PARAM_STROBE = 1'b0, PARAM_FAULTY = 1'b0, REDUNDANT_MODE = 1'b0;
  logic [7:0] PARAM_INDEX = 8'h00, PARAM_VALUE = 8'h00, PARAM_ACTIVE, FRAME_DATA;
  logic [47:0] STATION_HDR = 48'h0;
  logic [31:0] REDUN_STATUS = 32'h0, IRQ_HDR = 32'h0;
  logic [3:0] CHAN_COUNT = 4'h0;
  logic STORE_WE = 1'b0, IRQ_STROBE = 1'b0;
  logic [6:0] STORE_ADDR = 7'h00;
  logic [7:0] STORE_DATA = 8'h00;
  logic [1:0] IRQ_KIND = 2'h0;
  logic [7:0] mem [0:127];
  logic [7:0] exp [$];
  logic [7:0] v;
  logic [31:0] h;
  int errors = 0;
  int checked = 0;
  bit ok;
  always #5 MCLK = ~MCLK;
  diag_interrupt_frame_builder dut (
    .MCLK, .RESET, .SUPPLY_LOW(flt[0]), .SHUTDOWN_ON(flt[1]), .REF_JUNC_FAULT(flt[2]),
    .HART_NO_REPLY(flt[3]), .HART_PV_LIMIT(flt[4]), .HART_AUX_LIMIT(flt[5]), .ERR_CODE,
    .ERR_ACTIVE, .PARAM_STROBE, .PARAM_INDEX, .PARAM_VALUE, .PARAM_FAULTY, .PARAM_ACTIVE,
    .REDUNDANT_MODE, .STATION_HDR, .REDUN_STATUS, .CHAN_COUNT, .STORE_WE, .STORE_ADDR,
    .STORE_DATA, .IRQ_STROBE, .IRQ_KIND, .IRQ_HDR, .IRQ_BUSY, .FRAME_REQ, .FRAME_BUSY,
    .FRAME_VALID, .FRAME_DATA, .FRAME_LAST, .FRAME_READY
  );
  frame_reader reader (
    .clk(MCLK), .FRAME_BUSY, .FRAME_VALID, .FRAME_DATA, .FRAME_LAST, .FRAME_REQ,
    .FRAME_READY
  );
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, s);
    end
  endtask : check
  task automatic results;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  // fault pins in priority order: supply, shutdown, ref junction, hart comm, pv, aux
  function automatic logic [4:0] code_of(input logic [5:0] f);
    logic [4:0] t [6] = '{5'h11, 5'h18, 5'h15, 5'h13, 5'h1d, 5'h1e};
    for (int i = 0; i < 6; i++) if (f[i]) return t[i];
    return 5'h00;
  endfunction : code_of
  task automatic store_wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge MCLK);
    STORE_WE = 1'b1;
    STORE_ADDR = a;
    STORE_DATA = d;
    mem[a] = d;
    @(negedge MCLK);
    STORE_WE = 1'b0;
  endtask : store_wr
  task automatic param_wr(input logic [7:0] i, input logic [7:0] d, input bit bad);
    @(negedge MCLK);
    PARAM_STROBE = 1'b1;
    PARAM_INDEX = i;
    PARAM_VALUE = d;
    PARAM_FAULTY = bad;
    @(negedge MCLK);
    PARAM_STROBE = 1'b0;
  endtask : param_wr
  task automatic irq_raise(input logic [1:0] k, input logic [31:0] hd);
    @(negedge MCLK);
    IRQ_STROBE = 1'b1;
    IRQ_KIND = k;
    IRQ_HDR = hd;
    @(negedge MCLK);
    IRQ_STROBE = 1'b0;
  endtask : irq_raise
  // irq: -1 none, 0 diagnostic, 1 hardware, 2 remove/insert, 3 update
  task automatic frame(input int irq, input logic [7:0] ui, input logic [7:0] uc,
                       input bit stall);
    int hl, il, n;
    hl = REDUNDANT_MODE ? 10 : 6;
    il = irq < 0 ? 0 : irq == 0 ? 48 : irq == 1 ? 8 : irq == 2 ? 9 : 6;
    n = (64 - hl - il) / 3;
    if (CHAN_COUNT < n) n = CHAN_COUNT;
    exp.delete();
    for (int i = 0; i < 6; i++) exp.push_back(STATION_HDR[47 - 8 * i -: 8]);
    if (REDUNDANT_MODE) for (int i = 0; i < 4; i++) exp.push_back(REDUN_STATUS[31 - 8 * i -: 8]);
    for (int i = 0; i < 3 * n; i++) exp.push_back(mem[i]);
    if (irq == 3) exp = {exp, 8'h06, `UPD_TYPE_BYTE, `UPD_SLOT_BYTE, 8'h00, ui, uc};
    else if (irq >= 0) begin
      for (int i = 0; i < 4; i++) exp.push_back(IRQ_HDR[31 - 8 * i -: 8]);
      for (int i = 0; i < il - 4; i++) exp.push_back(mem[64 + i]);
    end
    reader.read_frame(stall, ok);
    check("frame end", 32'h1, ok);
    check("frame length", exp.size(), reader.count);
    foreach (exp[i]) check("frame byte", exp[i], reader.got[i]);
    @(negedge MCLK);
    check("irq pending after frame", 32'h0, IRQ_BUSY);
  endtask : frame
  initial begin
    void'($urandom(32'h1652));
    repeat (3) @(posedge MCLK);
    @(negedge MCLK);
    check("reset code", 32'h0, {ERR_ACTIVE, ERR_CODE, PARAM_ACTIVE, IRQ_BUSY, FRAME_VALID});
    RESET = 1'b0;
    for (int a = 0; a < 8'h6c; a++) store_wr(a[6:0], $urandom);
    STATION_HDR = {$urandom, $urandom};
    frame(-1, 8'h00, 8'h00, 1'b0);
    for (int k = 0; k < 4; k++) begin
      REDUNDANT_MODE = k[0];
      REDUN_STATUS = $urandom;
      CHAN_COUNT = (k == 3) ? 4'hf : $urandom;
      frame(-1, 8'h00, 8'h00, k[1]);
    end
    // full channel list forces truncation once a diagnostic interrupt is pending
    CHAN_COUNT = 4'hf;
    for (int k = 0; k < 6; k++) begin
      REDUNDANT_MODE = k[0];
      h = $urandom;
      irq_raise(k / 2, h);
      check("irq pending", 32'h1, IRQ_BUSY);
      irq_raise((k / 2 + 1) % 3, h); // refused: first interrupt keeps its kind
      frame(k / 2, 8'h00, 8'h00, k[0]);
    end
    REDUNDANT_MODE = 1'b0;
    CHAN_COUNT = 4'h2;
    param_wr(8'h05, 8'h5a, 1'b1);
    check("active after faulty", 32'h0, PARAM_ACTIVE);
    check("no error from faulty", 32'h0, {ERR_ACTIVE, ERR_CODE, IRQ_BUSY});
    frame(-1, 8'h00, 8'h00, 1'b0);
    v = $urandom | 8'h01;
    param_wr(8'h03, v, 1'b0);
    check("active after good", v, PARAM_ACTIVE);
    frame(3, 8'h03, 8'h00, 1'b1);
    param_wr(8'h07, v ^ 8'h0f, 1'b0);
    param_wr(8'h09, v ^ 8'hff, 1'b0);
    param_wr(8'h01, v, 1'b1);
    check("active kept", v ^ 8'hff, PARAM_ACTIVE);
    frame(3, 8'h09, 8'h01, 1'b0);
    param_wr(8'h04, v ^ 8'hff, 1'b0);
    frame(-1, 8'h00, 8'h00, 1'b0);
    for (int i = 0; i < 17; i++) begin
      @(negedge MCLK);
      flt = (i < 6) ? (6'h01 << i) : (i == 16) ? 6'h00 : $urandom;
      repeat (4) @(negedge MCLK);
      check("error code", code_of(flt), ERR_CODE);
      check("error active", |flt, ERR_ACTIVE);
    end
    results();
  end
  initial begin
    #400000;
    errors++;
    $display("[FAIL] watchdog expected end of tests seen hang");
    results();
  end
endmodule : tb_top
